/* pkg/sosel_defs.svh */
// Purpose : Offsets, bit positions and reset values of the oscillator select block
// Assumes : Included by bare name wherever a constant is needed
// Notes   : Definitions only, no logic
`ifndef SOSEL_DEFS_SVH
`define SOSEL_DEFS_SVH

// ==========================================================
// Register byte addresses
`define SOSEL_CLOCK_MODE_REGISTER_OFS   12'h000
`define SOSEL_RTC_CONTROL_REGISTER_OFS     12'h004
`define SOSEL_STATUS_OFS   12'h008

// ==========================================================
// Clock mode register fields
`define SOSEL_HIGH_LOW_CLOCK_SELECT_BIT    0
`define SOSEL_IDLEN_BIT    1
`define SOSEL_FMON_BIT     2
`define SOSEL_SLOWC_LSB    5
`define SOSEL_SLOWC_MSB    7
`define SOSEL_HIGH_LOW_CLOCK_SELECT_RST    1'b1
`define SOSEL_IDLEN_RST    1'b1
`define SOSEL_SLOWC_RST    3'h0

// ==========================================================
// RTC control register fields
`define SOSEL_QUICK_START_32K_CONTROL_BIT     4
`define SOSEL_QUICK_START_32K_CONTROL_RST     1'b0

// ==========================================================
// Status register fields
`define SOSEL_ST_MODE_LSB  0
`define SOSEL_ST_MODE_MSB  2
`define SOSEL_ST_LOW_BIT   3
`define SOSEL_ST_BUSY_BIT  4

// ==========================================================
// Slow divider: codes up to this one divide fM, above use fSL
`define SOSEL_SLOWC_MAXDIV 3'h5
`define SOSEL_DIV_W        6

`endif

/* pkg/sosel_pkg.sv */
// Purpose : Types shared by the oscillator select block
// Assumes : Constants live in sosel_defs.svh
// Notes   : Configuration options arrive as one packed struct
package sosel_pkg;

  // ==========================================================
  // High oscillator source options
  typedef enum logic [1:0]
  {
    SOSEL_HSRC_XTAL   = 2'b00,
    SOSEL_HSRC_IRC    = 2'b01,
    SOSEL_HSRC_ERC    = 2'b10,
    SOSEL_HSRC_EXTCLK = 2'b11
  } sosel_hsrc_e;

  // Internal RC fixed rate
  typedef enum logic [1:0]
  {
    SOSEL_IRC_4M  = 2'b00,
    SOSEL_IRC_8M  = 2'b01,
    SOSEL_IRC_12M = 2'b10
  } sosel_irc_e;

  // Operating mode reported to the core
  typedef enum logic [2:0]
  {
    SOSEL_MODE_NORMAL = 3'b000,
    SOSEL_MODE_SLOW0  = 3'b001,
    SOSEL_MODE_SLOW1  = 3'b010,
    SOSEL_MODE_IDLE   = 3'b011,
    SOSEL_MODE_SLEEP  = 3'b100
  } sosel_mode_e;

  // Switch sequencer states
  typedef enum logic [1:0]
  {
    SOSEL_SW_RUN      = 2'b00,
    SOSEL_SW_WAIT_OLD = 2'b01,
    SOSEL_SW_WAIT_NEW = 2'b10
  } sosel_sw_e;

  // Configuration options, fixed after programming
  typedef struct packed
  {
    sosel_hsrc_e highSrc;
    sosel_irc_e  ircFreq;
    logic        xtalHighRange;
    logic        lowExtXtal;
  } sosel_cfg_s;

  // Pin release flags, high means free for general I/O
  typedef struct packed
  {
    logic highPinA;
    logic highPinB;
    logic lowPinA;
    logic lowPinB;
  } sosel_gpio_s;

endpackage : sosel_pkg

/* rtl/sosel_clk_switch.sv */
// Purpose : Glitch-free change between two clock-enable streams
// Assumes : Ticks are one-cycle pulses in the clk_sys domain
// Notes   : Old source finishes its period, first new period is discarded
`timescale 1ns/1ps
`include "sosel_defs.svh"

module sosel_clk_switch
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic selB,
  input  wire logic tickA,
  input  wire logic tickB,
  output logic      tickOut,
  output logic      curB,
  output logic      busy
);

  sosel_pkg::sosel_sw_e state_q;
  logic                 cur_q;
  logic                 tickOut_q;
  logic                 oldTick;
  logic                 newTick;

  // Ticks of the source in use and of the one requested
  assign oldTick = cur_q ? tickB : tickA;
  assign newTick = cur_q ? tickA : tickB;

  // Sequencer: a partial period of either source never reaches the output
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_q <= sosel_pkg::SOSEL_SW_RUN;
      cur_q   <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        sosel_pkg::SOSEL_SW_RUN:
          if (selB != cur_q)
            state_q <= sosel_pkg::SOSEL_SW_WAIT_OLD;
        sosel_pkg::SOSEL_SW_WAIT_OLD:
          if (oldTick)
            state_q <= sosel_pkg::SOSEL_SW_WAIT_NEW;
        sosel_pkg::SOSEL_SW_WAIT_NEW:
          if (newTick)
          begin
            state_q <= sosel_pkg::SOSEL_SW_RUN;
            cur_q   <= ~cur_q;
          end
        default:
          state_q <= sosel_pkg::SOSEL_SW_RUN;
      endcase
    end
  end

  // Output tick, silent while waiting for the new source to align
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      tickOut_q <= 1'b0;
    else
      tickOut_q <= oldTick && (state_q != sosel_pkg::SOSEL_SW_WAIT_NEW);
  end

  assign tickOut = tickOut_q;
  assign curB    = cur_q;
  assign busy    = (state_q != sosel_pkg::SOSEL_SW_RUN);

endmodule : sosel_clk_switch

/* rtl/sosel_top.sv */
// Purpose : System oscillator source selection with APB registers
// Assumes : Oscillator activity arrives as one-cycle ticks on clk_sys
// Notes   : Every clock here is an enable pulse, never a real clock
`timescale 1ns/1ps
`include "sosel_defs.svh"

module sosel_top
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire sosel_pkg::sosel_cfg_s cfg,
  input  wire logic                highPinATick,
  input  wire logic                ircTick,
  input  wire logic                lowPinATick,
  input  wire logic                lircTick,
  input  wire logic                haltReq,
  input  wire logic                wakeReq,
  output logic                     sysClkEn,
  output logic                     subClkEn,
  output logic                     highOscEnable,
  output logic                     ircEnable,
  output sosel_pkg::sosel_irc_e    ircFreqSel,
  output logic                     xtalHighRange,
  output logic                     lowOscEnable,
  output logic                     quickStartOn,
  output sosel_pkg::sosel_gpio_s   gpioRelease,
  output sosel_pkg::sosel_mode_e   opMode
);

  // ==========================================================
  // Declarations
  logic                   high_low_clock_select_q;
  logic                   idleEn_q;
  logic [2:0]             slowc_q;
  logic                   quick_q;
  logic                   halted_q;
  logic [31:0]            prdata_q;
  logic [`SOSEL_DIV_W-1:0] divCnt_q;
  logic                   sysTick_q;
  logic                   subTick_q;
  logic                   highOn_q;
  sosel_pkg::sosel_mode_e mode_q;
  sosel_pkg::sosel_gpio_s gpio_q;
  logic                   setup;
  logic                   access;
  logic                   hitClk;
  logic                   hitRtc;
  logic                   hitSt;
  logic                   slowFromLow;
  logic                   fmOn;
  logic                   fmTick;
  logic                   lowTick;
  logic                   divTick;
  logic                   slowTick;
  logic                   swTick;
  logic                   swLow;
  logic                   swBusy;
  logic [`SOSEL_DIV_W-1:0] divMask;
  logic [31:0]            rdValue;

  // ==========================================================
  // APB decode
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign hitClk = (paddr == `SOSEL_CLOCK_MODE_REGISTER_OFS);
  assign hitRtc = (paddr == `SOSEL_RTC_CONTROL_REGISTER_OFS);
  assign hitSt  = (paddr == `SOSEL_STATUS_OFS);

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = access;
  assign pslverr = access && !(hitClk || hitRtc || hitSt);

  // Clock mode register written in the access phase only
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      high_low_clock_select_q  <= `SOSEL_HIGH_LOW_CLOCK_SELECT_RST;
      idleEn_q <= `SOSEL_IDLEN_RST;
      slowc_q  <= `SOSEL_SLOWC_RST;
    end
    else if (access && pwrite && hitClk)
    begin
      high_low_clock_select_q  <= pwdata[`SOSEL_HIGH_LOW_CLOCK_SELECT_BIT];
      idleEn_q <= pwdata[`SOSEL_IDLEN_BIT];
      slowc_q  <= pwdata[`SOSEL_SLOWC_MSB:`SOSEL_SLOWC_LSB];
    end
  end

  // Quick start bit, cleared at reset so start-up is fast
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      quick_q <= `SOSEL_QUICK_START_32K_CONTROL_RST;
    else if (access && pwrite && hitRtc)
      quick_q <= pwdata[`SOSEL_QUICK_START_32K_CONTROL_BIT];
  end

  // Read value assembled from live state
  always_comb
  begin
    rdValue = 32'h0000_0000;
    if (hitClk)
    begin
      rdValue[`SOSEL_HIGH_LOW_CLOCK_SELECT_BIT] = high_low_clock_select_q;
      rdValue[`SOSEL_IDLEN_BIT] = idleEn_q;
      rdValue[`SOSEL_FMON_BIT]  = highOn_q;
      rdValue[`SOSEL_SLOWC_MSB:`SOSEL_SLOWC_LSB] = slowc_q;
    end
    else if (hitRtc)
    begin
      rdValue[`SOSEL_QUICK_START_32K_CONTROL_BIT] = quick_q;
    end
    else if (hitSt)
    begin
      rdValue[`SOSEL_ST_MODE_MSB:`SOSEL_ST_MODE_LSB] = mode_q;
      rdValue[`SOSEL_ST_LOW_BIT]  = swLow;
      rdValue[`SOSEL_ST_BUSY_BIT] = swBusy;
    end
  end

  // Read data captured in the setup cycle so prdata is a flop
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      prdata_q <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata_q <= rdValue;
  end

  assign prdata = prdata_q;

  // ==========================================================
  // Halt and wake; a halt in the same cycle as a wake wins
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      halted_q <= 1'b0;
    else if (haltReq)
      halted_q <= 1'b1;
    else if (wakeReq)
      halted_q <= 1'b0;
  end

  // ==========================================================
  // Source selection by configuration options
  // Slow mode0 takes fSL; the high clock can then stop entirely
  assign slowFromLow = (slowc_q > `SOSEL_SLOWC_MAXDIV);
  assign fmOn        = !halted_q && (high_low_clock_select_q || !slowFromLow);

  // High tick: internal RC or whatever drives the first high pin
  assign fmTick  = fmOn &&
                   ((cfg.highSrc == sosel_pkg::SOSEL_HSRC_IRC) ? ircTick
                                                               : highPinATick);
  // Low tick: external 32768Hz crystal or internal 32k RC
  assign lowTick = cfg.lowExtXtal ? lowPinATick : lircTick;

  // ==========================================================
  // Slow divider fM/2 .. fM/64, one tick per wrap of the masked bits
  always_comb
  begin
    divMask = '0;
    for (int i = 0; i < `SOSEL_DIV_W; i++)
    begin
      if (i <= int'(slowc_q))
        divMask[i] = 1'b1;
    end
  end

  assign divTick = fmTick && ((divCnt_q & divMask) == divMask);

  // Divider counts only while fM runs; restarts on a new setting
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      divCnt_q <= '0;
    else if (access && pwrite && hitClk)
      divCnt_q <= '0;
    else if (fmTick)
      divCnt_q <= divCnt_q + `SOSEL_DIV_W'(1);
  end

  assign slowTick = slowFromLow ? lowTick : divTick;

  // ==========================================================
  // Glitch-free change between fM and fSLOW
  sosel_clk_switch u_switch
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .selB    (!high_low_clock_select_q),
    .tickA   (fmTick),
    .tickB   (slowTick),
    .tickOut (swTick),
    .curB    (swLow),
    .busy    (swBusy)
  );

  // System and sub clock enables, system clock stops in power down
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sysTick_q <= 1'b0;
      subTick_q <= 1'b0;
    end
    else
    begin
      sysTick_q <= swTick && !halted_q;
      subTick_q <= lowTick;
    end
  end

  assign sysClkEn = sysTick_q;
  assign subClkEn = subTick_q;

  // ==========================================================
  // Operating mode, derived from select bits and halt state
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      mode_q <= sosel_pkg::SOSEL_MODE_NORMAL;
    else if (halted_q)
      mode_q <= idleEn_q ? sosel_pkg::SOSEL_MODE_IDLE
                         : sosel_pkg::SOSEL_MODE_SLEEP;
    else if (high_low_clock_select_q)
      mode_q <= sosel_pkg::SOSEL_MODE_NORMAL;
    else if (slowFromLow)
      mode_q <= sosel_pkg::SOSEL_MODE_SLOW0;
    else
      mode_q <= sosel_pkg::SOSEL_MODE_SLOW1;
  end

  assign opMode = mode_q;

  // ==========================================================
  // Oscillator enables; a registered copy keeps outputs clean
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      highOn_q <= 1'b1;
    else
      highOn_q <= fmOn;
  end

  assign highOscEnable = highOn_q &&
                         (cfg.highSrc != sosel_pkg::SOSEL_HSRC_IRC);
  assign ircEnable     = highOn_q &&
                         (cfg.highSrc == sosel_pkg::SOSEL_HSRC_IRC);
  assign ircFreqSel    = cfg.ircFreq;
  // Range only means something for the crystal; others see low range
  assign xtalHighRange = (cfg.highSrc == sosel_pkg::SOSEL_HSRC_XTAL) &&
                         cfg.xtalHighRange;
  // The low oscillator never stops; the quick bit only trades current
  assign lowOscEnable  = 1'b1;
  assign quickStartOn  = !quick_q;

  // ==========================================================
  // Pin release to general I/O, per selected sources
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      gpio_q <= '0;
    else
    begin
      gpio_q.highPinA <= (cfg.highSrc == sosel_pkg::SOSEL_HSRC_IRC);
      gpio_q.highPinB <= (cfg.highSrc != sosel_pkg::SOSEL_HSRC_XTAL);
      gpio_q.lowPinA  <= !cfg.lowExtXtal;
      gpio_q.lowPinB  <= !cfg.lowExtXtal;
    end
  end

  assign gpioRelease = gpio_q;

endmodule : sosel_top

/* tb/sosel_osc_model.sv */
// Purpose : Tick sources standing in for the oscillators
// Assumes : All four run freely, also through reset
// Notes   : Periods are counted in clk_sys cycles
`timescale 1ns/1ps
module sosel_osc_model
#(
  parameter int HIGH_PER = 4,
  parameter int IRC_PER  = 3,
  parameter int LOW_PER  = 16,
  parameter int LIRC_PER = 24
)
(
  input  wire logic clk_sys,
  output logic      highPinATick,
  output logic      ircTick,
  output logic      lowPinATick,
  output logic      lircTick
);
  // ==========================================================
  // Period counters
  int hiCnt = 0;
  int irCnt = 0;
  int loCnt = 0;
  int liCnt = 0;

  // Both low sources keep running; the quick bit only costs power
  always_ff @(posedge clk_sys)
  begin
    hiCnt <= (hiCnt + 1) % HIGH_PER;
    irCnt <= (irCnt + 1) % IRC_PER;
    loCnt <= (loCnt + 1) % LOW_PER;
    liCnt <= (liCnt + 1) % LIRC_PER;
  end

  // One-cycle tick at the end of each period
  assign highPinATick = (hiCnt == 0);
  assign ircTick      = (irCnt == 0);
  assign lowPinATick  = (loCnt == 0);
  assign lircTick     = (liCnt == 0);
endmodule : sosel_osc_model

/* tb/sosel_top_assertions.sv */
// Purpose : Port-level checks of the oscillator select block
// Assumes : cfg only changes while reset is held
// Notes   : Bound into sosel_top
`timescale 1ns/1ps
module sosel_top_assertions
(
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire sosel_pkg::sosel_cfg_s  cfg,
  input wire logic                   lowPinATick,
  input wire logic                   lircTick,
  input wire logic                   haltReq,
  input wire logic                   sysClkEn,
  input wire logic                   subClkEn,
  input wire logic                   xtalHighRange,
  input wire logic                   quickStartOn,
  input wire sosel_pkg::sosel_irc_e  ircFreqSel,
  input wire sosel_pkg::sosel_gpio_s gpioRelease,
  input wire sosel_pkg::sosel_mode_e opMode
);
  // ==========================================================
  // Helpers
  wire logic lowTick = cfg.lowExtXtal ? lowPinATick : lircTick;
  wire logic halted  = (opMode == sosel_pkg::SOSEL_MODE_IDLE) ||
                       (opMode == sosel_pkg::SOSEL_MODE_SLEEP);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Properties
  a_quick_reset: assert property ($rose(rst_n) |-> quickStartOn)
    else $error("quick start not active after reset");
  a_irc_frees: assert property ($past(rst_n) && cfg.highSrc == sosel_pkg::SOSEL_HSRC_IRC
    |-> gpioRelease.highPinA && gpioRelease.highPinB) else $error("irc pins held");
  a_erc_frees: assert property ($past(rst_n) && cfg.highSrc == sosel_pkg::SOSEL_HSRC_ERC
    |-> !gpioRelease.highPinA && gpioRelease.highPinB) else $error("erc pins wrong");
  a_low_pins: assert property ($past(rst_n) |-> gpioRelease.lowPinA == !cfg.lowExtXtal
    && gpioRelease.lowPinB == !cfg.lowExtXtal) else $error("low pins wrong");
  a_irc_rate: assert property (ircFreqSel == cfg.ircFreq)
    else $error("irc rate differs");
  a_xtal_range: assert property (xtalHighRange == (cfg.xtalHighRange &&
    cfg.highSrc == sosel_pkg::SOSEL_HSRC_XTAL)) else $error("range flag wrong");
  a_halt_enter: assert property (haltReq |-> ##[1:2] halted)
    else $error("halt not entered");
  a_halt_quiet: assert property (halted [*3] |-> !sysClkEn)
    else $error("clock runs while halted");
  a_sub_follow: assert property ($past(rst_n) |-> subClkEn == $past(lowTick))
    else $error("sub clock lost");
  a_no_runt: assert property (sysClkEn |=> !sysClkEn)
    else $error("runt on system clock");

  // Main scenarios reached
  c_halted: cover property (halted);
  c_slow1: cover property (opMode == sosel_pkg::SOSEL_MODE_SLOW1);
  c_irc: cover property (gpioRelease.highPinA);
endmodule : sosel_top_assertions

bind sosel_top sosel_top_assertions i_sosel_top_assertions (.*);

/* tb/sosel_top_test.sv */
// Purpose : Self-checking bench of the oscillator select block
// Assumes : Zero-wait APB slave, ticks from sosel_osc_model
// Notes   : cfg only changes while reset is held
`timescale 1ns/1ps
`include "sosel_defs.svh"
module sosel_top_test;
  localparam int HP = 4;
  localparam int LP = 16;
  localparam int IP = 3;
  localparam int LIP = 24;
  logic                   clk_sys = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [11:0]            paddr = 12'h0;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  sosel_pkg::sosel_cfg_s  cfg = 6'h07;
  logic                   haltReq = 1'b0;
  logic                   wakeReq = 1'b0;
  logic                   hiT, irT, loT, liT;
  logic                   sysClkEn, subClkEn, ircEnable, lowOscEnable, quickStartOn;
  logic                   highOscEnable, xtalHighRange;
  sosel_pkg::sosel_irc_e  ircFreqSel;
  sosel_pkg::sosel_gpio_s gpioRelease;
  sosel_pkg::sosel_mode_e opMode;
  int                     num_errors = 0;
  int                     check_count = 0;

  // ==========================================================
  // Clock, partner and device
  always #50 clk_sys = ~clk_sys;
  sosel_osc_model #(.HIGH_PER(HP), .IRC_PER(IP), .LOW_PER(LP), .LIRC_PER(LIP))
    i_sosel_osc_model (.clk_sys(clk_sys),
    .highPinATick(hiT), .ircTick(irT), .lowPinATick(loT), .lircTick(liT));
  sosel_top i_sosel_top (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg(cfg), .highPinATick(hiT), .ircTick(irT), .lowPinATick(loT),
    .lircTick(liT), .haltReq(haltReq), .wakeReq(wakeReq), .sysClkEn(sysClkEn),
    .subClkEn(subClkEn), .highOscEnable(highOscEnable), .ircEnable(ircEnable),
    .ircFreqSel(ircFreqSel), .xtalHighRange(xtalHighRange),
    .lowOscEnable(lowOscEnable), .quickStartOn(quickStartOn),
    .gpioRelease(gpioRelease), .opMode(opMode));

  // ==========================================================
  // Shared tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask : do_reset

  // One transfer; an idle cycle follows so psel is never rewritten in one step
  task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 8);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
    if (n >= 8)
    begin
      num_errors++;
      final_report();
    end
  endtask : apb

  task automatic count_pulses(input int cyc, output int s, output int u);
    s = 0;
    u = 0;
    repeat (cyc)
    begin
      @(posedge clk_sys);
      s += int'(sysClkEn === 1'b1);
      u += int'(subClkEn === 1'b1);
    end
  endtask : count_pulses

  // ==========================================================
  // Scenarios
  task automatic test_regs();
    logic [31:0] d;
    logic        e;
    apb(1'b0, `SOSEL_CLOCK_MODE_REGISTER_OFS, 32'h0, d, e);
    chk(d, 32'h0000_0007);
    apb(1'b0, `SOSEL_RTC_CONTROL_REGISTER_OFS, 32'h0, d, e);
    chk(d, 32'h0);
    chk(32'(quickStartOn), 32'h1);
    apb(1'b1, `SOSEL_RTC_CONTROL_REGISTER_OFS, 32'h0000_0010, d, e);
    apb(1'b0, `SOSEL_RTC_CONTROL_REGISTER_OFS, 32'h0, d, e);
    chk(d, 32'h0000_0010);
    chk(32'(quickStartOn), 32'h0);
    chk(32'(lowOscEnable), 32'h1);
    apb(1'b0, 12'h00C, 32'h0, d, e);
    chk(32'(e), 32'h1);
    $display("test regs done");
  endtask : test_regs

  // Every source option, rate option and range option goes through a reset
  task automatic test_pins();
    int n, u;
    for (int s = 0; s < 4; s++)
      for (int x = 0; x < 2; x++)
      begin
        cfg.highSrc <= sosel_pkg::sosel_hsrc_e'(s);
        cfg.ircFreq <= sosel_pkg::sosel_irc_e'(s % 3);
        cfg.xtalHighRange <= x[0];
        cfg.lowExtXtal <= x[0];
        do_reset();
        repeat (2) @(posedge clk_sys);
        chk(32'(gpioRelease), {28'h0, s == 1, s != 0, x == 0, x == 0});
        chk(32'(ircEnable), 32'(s == 1));
        chk(32'(highOscEnable), 32'(s != 1));
        chk(32'(ircFreqSel), 32'(s % 3));
        chk(32'(xtalHighRange), 32'(s == 0 && x == 1));
        count_pulses(48, n, u);
        chk(32'(n), (s == 1) ? 48 / IP : 48 / HP);
        chk(32'(u), (x == 1) ? 48 / LP : 48 / LIP);
      end
    $display("test pins done");
  endtask : test_pins

  // Codes 0..7 on the slow source, then back to the high source
  task automatic test_rates();
    logic [31:0] d;
    logic        e;
    int          s, u, ex, em;
    for (int k = 0; k < 9; k++)
    begin
      apb(1'b1, `SOSEL_CLOCK_MODE_REGISTER_OFS, (k < 8) ? {24'h0, 3'(k), 5'h02} : 32'h3, d, e);
      repeat (600) @(posedge clk_sys);
      count_pulses(512, s, u);
      ex = (k < 6) ? 512 / (HP << (k + 1)) : (k < 8) ? 512 / LP : 512 / HP;
      chk(32'(s >= ex - 1 && s <= ex + 1), 32'h1);
      em = (k < 6) ? 2 : (k < 8) ? 1 : 0;
      chk(32'(opMode), 32'(em));
      apb(1'b0, `SOSEL_STATUS_OFS, 32'h0, d, e);
      chk(d, {27'h0, 1'b0, k < 8, 3'(em)});
    end
    $display("test rates done");
  endtask : test_rates

  task automatic test_halt();
    logic [31:0] d;
    logic        e;
    int          s, u;
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, `SOSEL_CLOCK_MODE_REGISTER_OFS, (m == 0) ? 32'h3 : 32'h1, d, e);
      haltReq <= 1'b1;
      @(posedge clk_sys);
      haltReq <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk(32'(opMode), (m == 0) ? 32'h3 : 32'h4);
      count_pulses(200, s, u);
      chk(32'(s), 32'h0);
      chk(32'(u > 0), 32'h1);
      chk(32'(highOscEnable), 32'h0);
      apb(1'b0, `SOSEL_CLOCK_MODE_REGISTER_OFS, 32'h0, d, e);
      chk(d, (m == 0) ? 32'h3 : 32'h1);
      wakeReq <= 1'b1;
      @(posedge clk_sys);
      wakeReq <= 1'b0;
      repeat (20) @(posedge clk_sys);
      chk(32'(opMode), 32'h0);
      chk(32'(highOscEnable), 32'h1);
    end
    $display("test halt done");
  endtask : test_halt

  // Main sequence
  initial
  begin
    do_reset();
    test_regs();
    test_pins();
    test_rates();
    test_halt();
    final_report();
  end
endmodule : sosel_top_test
